// ===== rtl/pem_blink.sv
// Error LED blink pattern generator.
`timescale 1ns/1ns
`default_nettype none
module pem_blink #(
  parameter logic [26:0] HALF_MEM = 27'h0000001,
  parameter logic [26:0] HALF_CS = 27'h0000001,
  parameter logic [26:0] HALF_CL = 27'h0000001,
  parameter logic [26:0] HALF_TEMP = 27'h0000001,
  parameter logic [26:0] HALF_MACRO = 27'h0000001
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire pem_pkg::pem_pat_e pattern,
  output logic ledOn
);
  typedef struct packed {
    logic [26:0] cnt;
    logic [1:0] cyc;
    logic led;
    pem_pkg::pem_pat_e pat;
  } pem_blink_s;

  pem_blink_s st_r;
  pem_blink_s st_nxt;
  logic [26:0] half;

  // ==================================================
  // Half period of the current cycle; the cutter group uses three short then one long.
  always_comb begin
    unique case (st_r.pat)
      pem_pkg::PAT_MEM: half = HALF_MEM;
      pem_pkg::PAT_CUT: half = (st_r.cyc == 2'(pem_pkg::CUT_SHORT_RPT)) ? HALF_CL : HALF_CS;
      pem_pkg::PAT_TEMP: half = HALF_TEMP;
      pem_pkg::PAT_MACRO: half = HALF_MACRO;
      default: half = HALF_MEM;
    endcase
  end

  // ==================================================
  // A new pattern other than PAT_OFF restarts with the LED lit, so a change is seen at once.
  always_comb begin
    st_nxt = st_r;
    if (pattern != st_r.pat) begin
      st_nxt.pat = pattern;
      st_nxt.cnt = '0;
      st_nxt.cyc = '0;
      st_nxt.led = (pattern != pem_pkg::PAT_OFF);
    end else if (st_r.pat == pem_pkg::PAT_OFF) begin
      st_nxt.led = 1'b0;
    end else if (st_r.pat == pem_pkg::PAT_ON) begin
      st_nxt.led = 1'b1;
    end else if (st_r.cnt >= half - 27'h0000001) begin
      st_nxt.cnt = '0;
      st_nxt.led = ~st_r.led;
      if (!st_r.led) begin
        st_nxt.cyc = (st_r.cyc == 2'(pem_pkg::CUT_SHORT_RPT)) ? 2'h0 : st_r.cyc + 2'h1;
      end
    end else begin
      st_nxt.cnt = st_r.cnt + 27'h0000001;
    end
  end

  // ==================================================
  // State register.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '{cnt: '0, cyc: '0, led: 1'b0, pat: pem_pkg::PAT_OFF};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign ledOn = st_r.led;
endmodule // pem_blink
`default_nettype wire

// ===== rtl/pem_monitor.sv
// Printer error monitor: error classification, indication and host lines.
`timescale 1ns/1ns
`default_nettype none
module pem_monitor #(
  parameter int unsigned HALF_MEM = pem_pkg::MEM_CYC_MS * pem_pkg::CYC_PER_MS / 2,
  parameter int unsigned HALF_CS = pem_pkg::CUT_SHORT_MS * pem_pkg::CYC_PER_MS / 2,
  parameter int unsigned HALF_CL = pem_pkg::CUT_LONG_MS * pem_pkg::CYC_PER_MS / 2,
  parameter int unsigned HALF_TEMP = pem_pkg::TEMP_CYC_MS * pem_pkg::CYC_PER_MS / 2,
  parameter int unsigned HALF_MACRO = pem_pkg::MACRO_CYC_MS * pem_pkg::CYC_PER_MS / 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Pins, synchronised here.
  input wire logic cutterEnableSelect,
  input wire logic cutterPresent,
  input wire logic paperPresent,
  input wire logic headLeverUp,
  input wire logic platenPresent,
  input wire logic mechTypeSel,
  input wire logic lineFeedSwitch,
  // Same-clock inputs from the rest of the controller.
  input wire logic ramTestDone,
  input wire logic ramTestFail,
  input wire logic cutterLocked,
  input wire logic macroWait,
  input wire logic printerBusy,
  input wire logic [7:0] driveSupplyVoltage,
  input wire logic signed [7:0] headTemp,
  // Indicators and host lines.
  output logic errorLed,
  output logic paperOutLed,
  output logic paperEmptyLine,
  output logic fault_n_out,
  output logic busy,
  output logic haltPrint,
  output logic selfTestActive
);
  typedef struct packed {
    logic [pem_pkg::PIN_N-1:0] pinS1;
    logic [pem_pkg::PIN_N-1:0] pinS2;
    pem_pkg::pem_phase_e phase;
    logic memErr;
    logic cutErr;
    logic voltErr;
    logic lockErr;
    logic tempLow;
    logic tempHigh;
    logic lfPrev;
    logic paperOut;
    logic paperEmpty;
    logic faultN;
    logic busy;
    logic halt;
    logic selfTest;
    pem_pkg::pem_pat_e pat;
  } pem_state_s;

  pem_state_s st_r;
  pem_state_s st_nxt;
  logic [pem_pkg::PIN_N-1:0] pinRaw;
  logic noPaper;
  logic posBad;
  logic voltOut;
  logic lfEdge;
  logic running;
  logic alarm;

  assign pinRaw = {lineFeedSwitch, mechTypeSel, platenPresent, headLeverUp,
                   paperPresent, cutterPresent, cutterEnableSelect};

  // ==================================================
  // Conditions seen on the synchronised pins and on the analog readings.
  always_comb begin
    running = (st_r.phase == pem_pkg::PH_RUN);
    noPaper = ~st_r.pinS2[pem_pkg::PIN_PAPER];
    // Mechanism type low selects the lever variant, high the platen variant.
    posBad = st_r.pinS2[pem_pkg::PIN_MECH] ? ~st_r.pinS2[pem_pkg::PIN_PLATEN]
                                           : st_r.pinS2[pem_pkg::PIN_LEVER_UP];
    voltOut = (driveSupplyVoltage < pem_pkg::VOLT_MIN) ||
              (driveSupplyVoltage > pem_pkg::VOLT_MAX);
    lfEdge = st_r.pinS2[pem_pkg::PIN_LF] & ~st_r.lfPrev;
    alarm = st_r.memErr | st_r.cutErr | st_r.voltErr | st_r.lockErr |
            st_r.tempLow | st_r.tempHigh | posBad | noPaper;
  end

  // ==================================================
  // Next state: phase, latched errors, then the registered outputs.
  always_comb begin
    st_nxt = st_r;
    st_nxt.pinS1 = pinRaw;
    st_nxt.pinS2 = st_r.pinS1;
    st_nxt.lfPrev = st_r.pinS2[pem_pkg::PIN_LF];
    unique case (st_r.phase)
      pem_pkg::PH_SELFTEST: begin
        // Peripheral checks happen here only, once the RAM test reports.
        if (ramTestDone) begin
          st_nxt.memErr = ramTestFail;
          st_nxt.cutErr = st_r.pinS2[pem_pkg::PIN_CUT_EN] &
                          ~st_r.pinS2[pem_pkg::PIN_CUT_PRES];
          st_nxt.phase = ramTestFail ? pem_pkg::PH_DEAD : pem_pkg::PH_RUN;
        end
      end
      pem_pkg::PH_RUN: begin
        // Set wins over the switch clear, so a fault still present is kept.
        st_nxt.voltErr = voltOut | (st_r.voltErr & ~lfEdge);
        st_nxt.lockErr = cutterLocked | (st_r.lockErr & ~lfEdge);
        // Low limit releases at 0 C; high limit waits for 60 C.
        if (headTemp < pem_pkg::TEMP_LOW) begin
          st_nxt.tempLow = 1'b1;
        end else begin
          st_nxt.tempLow = 1'b0;
        end
        if (headTemp >= pem_pkg::TEMP_TRIP) begin
          st_nxt.tempHigh = 1'b1;
        end else if (headTemp <= pem_pkg::TEMP_RESUME) begin
          st_nxt.tempHigh = 1'b0;
        end
      end
      pem_pkg::PH_DEAD: begin
        // Memory failure has no way out but a reset.
        st_nxt.phase = pem_pkg::PH_DEAD;
      end
      default: st_nxt.phase = pem_pkg::PH_SELFTEST;
    endcase
    // Phase flag is registered with the phase so the output comes from a flip-flop.
    st_nxt.selfTest = (st_nxt.phase == pem_pkg::PH_SELFTEST);
    // The cutter error is left untouched outside the self-test phase.
    st_nxt.paperOut = noPaper;
    st_nxt.paperEmpty = noPaper;
    st_nxt.faultN = ~(alarm & ~(st_r.phase == pem_pkg::PH_SELFTEST));
    st_nxt.halt = alarm | ~running;
    st_nxt.busy = printerBusy | alarm | ~running;
    // Fixed priority: memory, cutter, head position, voltage, temperature, macro.
    if (st_r.memErr) begin
      st_nxt.pat = pem_pkg::PAT_MEM;
    end else if (st_r.cutErr | st_r.lockErr) begin
      st_nxt.pat = pem_pkg::PAT_CUT;
    end else if (running & (posBad | st_r.voltErr)) begin
      st_nxt.pat = pem_pkg::PAT_ON;
    end else if (st_r.tempLow | st_r.tempHigh) begin
      st_nxt.pat = pem_pkg::PAT_TEMP;
    end else if (running & macroWait) begin
      st_nxt.pat = pem_pkg::PAT_MACRO;
    end else begin
      st_nxt.pat = pem_pkg::PAT_OFF;
    end
  end

  // ==================================================
  // State register; a low clock enable freezes everything.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '{pinS1: pem_pkg::PIN_RST, pinS2: pem_pkg::PIN_RST,
                phase: pem_pkg::PH_SELFTEST, memErr: 1'b0, cutErr: 1'b0,
                voltErr: 1'b0, lockErr: 1'b0, tempLow: 1'b0, tempHigh: 1'b0,
                lfPrev: 1'b0, paperOut: 1'b0, paperEmpty: 1'b0, faultN: 1'b1,
                busy: 1'b1, halt: 1'b1, selfTest: 1'b1, pat: pem_pkg::PAT_OFF};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ==================================================
  // LED pattern generator; its output is a flip-flop of its own.
  pem_blink #(
    .HALF_MEM(HALF_MEM[26:0]),
    .HALF_CS(HALF_CS[26:0]),
    .HALF_CL(HALF_CL[26:0]),
    .HALF_TEMP(HALF_TEMP[26:0]),
    .HALF_MACRO(HALF_MACRO[26:0])
  ) u_blink (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .pattern(st_r.pat),
    .ledOn(errorLed)
  );

  assign paperOutLed = st_r.paperOut;
  assign paperEmptyLine = st_r.paperEmpty;
  assign fault_n_out = st_r.faultN;
  assign busy = st_r.busy;
  assign haltPrint = st_r.halt;
  assign selfTestActive = st_r.selfTest;

  // ==================================================
  // Checks on the block's own behaviour.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_paper_led;
    ce && noPaper |=> paperOutLed && paperEmptyLine;
  endproperty
  a_paper_led: assert property (p_paper_led) else $error("paper LED missed");

  property p_fault;
    ce && alarm && running |=> !fault_n_out && haltPrint;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not shown");

  property p_busy;
    ce && (alarm || !running) |=> busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy low in error");

  property p_hot_hold;
    ce && running && st_r.tempHigh && headTemp > pem_pkg::TEMP_RESUME |=> st_r.tempHigh;
  endproperty
  a_hot_hold: assert property (p_hot_hold) else $error("hot released early");

  property p_cold_go;
    ce && running && st_r.tempLow && headTemp >= pem_pkg::TEMP_LOW |=> !st_r.tempLow;
  endproperty
  a_cold_go: assert property (p_cold_go) else $error("cold not released");

  property p_volt;
    ce && running && voltOut |=> st_r.voltErr ##1 (busy || !$past(ce));
  endproperty
  a_volt: assert property (p_volt) else $error("voltage not flagged");

  property p_cut_keep;
    ce && st_r.cutErr |=> st_r.cutErr;
  endproperty
  a_cut_keep: assert property (p_cut_keep) else $error("cutter error lost");

  property p_no_late_check;
    ce && running && !st_r.cutErr |=> !st_r.cutErr;
  endproperty
  a_no_late_check: assert property (p_no_late_check) else $error("late check");

  property p_mem;
    ce && st_r.phase == pem_pkg::PH_SELFTEST && ramTestDone && ramTestFail
      |=> st_r.memErr ##1 (!ce || st_r.pat == pem_pkg::PAT_MEM);
  endproperty
  a_mem: assert property (p_mem) else $error("memory error missed");

  property p_lock_clr;
    ce && running && st_r.lockErr && lfEdge && !cutterLocked |=> !st_r.lockErr;
  endproperty
  a_lock_clr: assert property (p_lock_clr) else $error("lock not cleared");

  property p_paper_only;
    ce && st_r.pat == pem_pkg::PAT_OFF ##1 ce && st_r.pat == pem_pkg::PAT_OFF
      |=> !errorLed;
  endproperty
  a_paper_only: assert property (p_paper_only) else $error("LED lit idle");

  c_mem: cover property (ce && st_r.memErr);
  c_lock_clr: cover property (ce && st_r.lockErr && lfEdge && !cutterLocked);
  c_hot: cover property (ce && st_r.tempHigh);
  c_led: cover property (ce && !errorLed ##1 errorLed);
endmodule // pem_monitor
`default_nettype wire

// ===== rtl/pem_pkg.sv
// Constants shared by the printer error monitor.
package pem_pkg;
  // ==================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned MEM_CYC_MS = 200;
  localparam int unsigned CUT_SHORT_MS = 150;
  localparam int unsigned CUT_LONG_MS = 500;
  localparam int unsigned CUT_SHORT_RPT = 3;
  localparam int unsigned TEMP_CYC_MS = 1000;
  localparam int unsigned MACRO_CYC_MS = 500;
  localparam int CNT_W = 27;
  // ==================================================
  // Analog thresholds: supply in 0.1 V units, head in deg C
  localparam logic [7:0] VOLT_MIN = 8'h2A;
  localparam logic [7:0] VOLT_MAX = 8'h55;
  localparam logic signed [7:0] TEMP_LOW = 8'sh00;
  localparam logic signed [7:0] TEMP_TRIP = 8'sh41;
  localparam logic signed [7:0] TEMP_RESUME = 8'sh3C;
  // ==================================================
  // Positions of the synchronised pin inputs
  localparam int PIN_N = 7;
  localparam int PIN_CUT_EN = 0;
  localparam int PIN_CUT_PRES = 1;
  localparam int PIN_PAPER = 2;
  localparam int PIN_LEVER_UP = 3;
  localparam int PIN_PLATEN = 4;
  localparam int PIN_MECH = 5;
  localparam int PIN_LF = 6;
  // Reset value of the synchronisers matches the idle pins (paper and platen present).
  // This keeps a false paper-out or platen fault from showing just after reset.
  localparam logic [PIN_N-1:0] PIN_RST = 7'h14;
  // ==================================================
  // Types
  typedef enum logic [2:0] {
    PAT_OFF, PAT_ON, PAT_MEM, PAT_CUT, PAT_TEMP, PAT_MACRO
  } pem_pat_e;
  typedef enum logic [1:0] {
    PH_SELFTEST, PH_RUN, PH_DEAD
  } pem_phase_e;
endpackage

// ===== tb/pem_host_model.sv
// Host side model: offers parallel bytes and takes note of every one it sends.
`timescale 1ns/1ns
`default_nettype none
module pem_host_model (
  input wire logic ref_clk,
  input wire logic busy,
  input wire logic sendReq,
  output int sentCount
);
  // ==================================================
  // Byte offer
  int cnt = 0;
  // A byte is only handed over while busy is seen low at the edge, so a busy device loses nothing.
  always @(posedge ref_clk) begin
    if (sendReq && busy === 1'b0) begin
      cnt <= cnt + 1;
    end
  end
  assign sentCount = cnt;
endmodule // pem_host_model
`default_nettype wire

// ===== tb/tb_pem_monitor.sv
// Self-checking bench for the printer error monitor.
`timescale 1ns/1ns
`default_nettype none
module tb_pem_monitor;
  logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, sendReq = 1'b0;
  logic cutterEnableSelect = 1'b0, cutterPresent = 1'b0, paperPresent = 1'b1, headLeverUp = 1'b0;
  logic platenPresent = 1'b1, mechTypeSel = 1'b0, lineFeedSwitch = 1'b0, ramTestDone = 1'b0;
  logic ramTestFail = 1'b0, cutterLocked = 1'b0, macroWait = 1'b0, printerBusy = 1'b0;
  logic [7:0] driveSupplyVoltage = 8'h48;
  logic signed [7:0] headTemp = 8'sh19;
  logic errorLed, paperOutLed, paperEmptyLine, fault_n_out, busy, haltPrint, selfTestActive;
  int fail_count = 0, n_checks = 0, sentCount, n, i;
  logic [7:0] vt [4] = '{8'h2A, 8'h29, 8'h55, 8'h56};
  logic signed [7:0] tt [8] = '{8'sh19, 8'sh40, 8'sh41, 8'sh3D, 8'sh3C, 8'sh00, 8'shFF, 8'sh00};
  logic te [8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  // ==================================================
  // Clock, design and host
  always #5 ref_clk = ~ref_clk;
  // Blink halves are shortened so that every pattern repeats within a few hundred cycles.
  pem_monitor #(.HALF_MEM(4), .HALF_CS(3), .HALF_CL(10), .HALF_TEMP(20), .HALF_MACRO(10)) u_pem_monitor (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .cutterEnableSelect(cutterEnableSelect),
    .cutterPresent(cutterPresent), .paperPresent(paperPresent), .headLeverUp(headLeverUp),
    .platenPresent(platenPresent), .mechTypeSel(mechTypeSel), .lineFeedSwitch(lineFeedSwitch),
    .ramTestDone(ramTestDone), .ramTestFail(ramTestFail), .cutterLocked(cutterLocked),
    .macroWait(macroWait), .printerBusy(printerBusy), .driveSupplyVoltage(driveSupplyVoltage),
    .headTemp(headTemp), .errorLed(errorLed), .paperOutLed(paperOutLed), .paperEmptyLine(paperEmptyLine),
    .fault_n_out(fault_n_out), .busy(busy), .haltPrint(haltPrint), .selfTestActive(selfTestActive));
  pem_host_model u_pem_host_model (.ref_clk(ref_clk), .busy(busy), .sendReq(sendReq), .sentCount(sentCount));
  // ==================================================
  // Helpers
  task automatic step(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic chk(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask
  task automatic chkn(input int got, input int exp, input string msg);
    n_checks++;
    if (got != exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %0d", $time, msg, got);
    end
  endtask
  // Compares paperOutLed, paperEmptyLine, fault_n_out, busy and haltPrint at once.
  task automatic outs(input logic [4:0] exp, input string msg);
    chk(({paperOutLed, paperEmptyLine, fault_n_out, busy, haltPrint} === exp), 1'b1, msg);
  endtask
  // Pins are set before reset so that the synchronisers have settled when self-test ends.
  task automatic doReset(input logic en, input logic pres, input logic fail);
    cutterEnableSelect = en;
    cutterPresent = pres;
    rst = 1'b1;
    step(4);
    rst = 1'b0;
    step(3);
    chk(selfTestActive, 1'b1, "self-test phase");
    ramTestDone = 1'b1;
    ramTestFail = fail;
    step(1);
    ramTestDone = 1'b0;
    step(4);
  endtask
  // Length of the next lit stretch of the error LED, bounded so a stuck LED cannot hang the run.
  task automatic hiRun(output int n);
    int k;
    n = 0;
    k = 0;
    while (errorLed !== 1'b0 && k < 200) begin step(1); k++; end
    while (errorLed !== 1'b1 && k < 400) begin step(1); k++; end
    while (errorLed === 1'b1 && n < 200) begin step(1); n++; end
  endtask
  task automatic cutSeq();
    int n, j;
    j = 0;
    hiRun(n);
    while (n != 10 && j < 6) begin hiRun(n); j++; end
    chkn(n, 10, "cutter long lit");
    for (j = 0; j < 3; j++) begin hiRun(n); chkn(n, 3, "cutter short lit"); end
  endtask
  task automatic steady(input string msg);
    for (int j = 0; j < 4; j++) begin step(8); chk(errorLed, 1'b1, msg); end
  endtask
  task automatic pressLf();
    lineFeedSwitch = 1'b1;
    step(2);
    lineFeedSwitch = 1'b0;
    step(6);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==================================================
  // Watchdog: the tests need well under a thousand cycles, so this span of 30000 cycles is generous.
  initial begin
    #300000;
    fail_count++;
    give_verdict();
  end
  // ==================================================
  // Tests
  initial begin
    step(1);
    doReset(1'b1, 1'b1, 1'b0);
    chk(selfTestActive, 1'b0, "run phase");
    outs(5'b00100, "idle outputs");
    sendReq = 1'b1;
    step(4);
    sendReq = 1'b0;
    chkn(sentCount, 4, "host bytes");
    printerBusy = 1'b1;
    step(2);
    chk(busy, 1'b1, "busy follows datapath");
    sendReq = 1'b1;
    step(3);
    sendReq = 1'b0;
    printerBusy = 1'b0;
    chkn(sentCount, 4, "no byte while busy");
    // A cutter lost in run phase is not a peripheral error.
    cutterPresent = 1'b0;
    step(8);
    outs(5'b00100, "cutter ignored in run");
    cutterPresent = 1'b1;
    // A low clock enable freezes the synchronisers, so a lever change waits for it.
    ce = 1'b0;
    headLeverUp = 1'b1;
    step(6);
    chk(haltPrint, 1'b0, "frozen while disabled");
    ce = 1'b1;
    step(6);
    chk(haltPrint, 1'b1, "lever seen after enable");
    headLeverUp = 1'b0;
    step(6);
    for (i = 0; i < 4; i++) begin
      driveSupplyVoltage = vt[i];
      step(4);
      chk(busy, i[0], "voltage window");
      if (i[0]) begin
        steady("voltage led steady");
        driveSupplyVoltage = 8'h48;
        step(4);
        outs(5'b00011, "voltage error latched");
        pressLf();
        outs(5'b00100, "voltage cleared");
      end
    end
    for (i = 0; i < 8; i++) begin
      headTemp = tt[i];
      step(4);
      chk(haltPrint, te[i], "temperature window");
      if (i == 2) begin
        hiRun(n);
        chkn(n, 20, "temperature blink");
      end
    end
    paperPresent = 1'b0;
    headLeverUp = 1'b1;
    step(6);
    outs(5'b11011, "paper out with lever up");
    steady("lever led steady");
    headLeverUp = 1'b0;
    step(6);
    chk(errorLed, 1'b0, "no paper keeps led dark");
    step(25);
    chk(errorLed, 1'b0, "no paper keeps led dark");
    paperPresent = 1'b1;
    mechTypeSel = 1'b1;
    headLeverUp = 1'b1;
    step(6);
    outs(5'b00100, "lever ignored on platen variant");
    platenPresent = 1'b0;
    step(6);
    chk(haltPrint, 1'b1, "platen missing");
    steady("platen led steady");
    platenPresent = 1'b1;
    mechTypeSel = 1'b0;
    headLeverUp = 1'b0;
    cutterLocked = 1'b1;
    headTemp = 8'sh41;
    step(3);
    cutterLocked = 1'b0;
    cutSeq();
    headTemp = 8'sh19;
    step(4);
    chk(haltPrint, 1'b1, "lock latched");
    pressLf();
    outs(5'b00100, "lock cleared");
    macroWait = 1'b1;
    hiRun(n);
    chkn(n, 10, "macro blink");
    macroWait = 1'b0;
    doReset(1'b1, 1'b0, 1'b0);
    cutSeq();
    cutterPresent = 1'b1;
    step(8);
    cutSeq();
    doReset(1'b1, 1'b1, 1'b0);
    outs(5'b00100, "cutter error cleared by reset");
    doReset(1'b0, 1'b0, 1'b1);
    hiRun(n);
    chkn(n, 4, "memory blink");
    chk(busy, 1'b1, "dead after memory error");
    doReset(1'b0, 1'b0, 1'b0);
    chk(errorLed, 1'b0, "memory error gone");
    give_verdict();
  end
endmodule // tb_pem_monitor
`default_nettype wire
